// file: hdl/cbd_pkg.sv
package cbd_pkg;

   // Address qualifiers for the memory page decoder.
   localparam logic [3:0] PAGE_HI_ONBOARD = 4'hC;
   localparam logic [3:0] PAGE_HI_ZERO    = 4'h0;
   localparam logic [1:0] PAGE_CODE_ROM0  = 2'h0;

   // Index of each page select inside the page select vector.
   localparam int PAGE_ROM0   = 0;
   localparam int PAGE_ROM1   = 1;
   localparam int PAGE_SYSRAM = 2;
   localparam int PAGE_DISP   = 3;
   localparam int PAGE_COUNT  = 4;

   // Address qualifier and port indices for the port decoders.
   localparam logic [4:0] PORT_HI        = 5'h1F;
   localparam int         PORT_COUNT     = 8;
   localparam int         PORT_KBD_IDX   = 4;
   localparam int         PORT_PAR_IDX   = 5;
   localparam int         INT_PORT_COUNT = 4;

   // Number of fetch cycles that keep the start-up remap active.
   localparam logic [2:0] PHANTOM_FETCHES = 3'h4;

   // Level seen on an undriven, pulled-up byte lane.
   localparam logic [7:0] BUS_PULLUP = 8'hFF;

   // Input multiplexer source, coded as {select_b, select_a}.
   typedef enum logic [1:0] {
      SRC_INTERNAL = 2'b00,
      SRC_PARALLEL = 2'b01,
      SRC_KEYBOARD = 2'b10,
      SRC_BIDIR    = 2'b11
   } cbd_src_t;

   // Wait-state request state.
   typedef enum logic [0:0] {
      RDY_IDLE = 1'b0,
      RDY_WAIT = 1'b1
   } cbd_rdy_t;

endpackage : cbd_pkg

// file: hdl/cbd_sel_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cbd_sel_if;
   logic [3:0] page_n;
   logic       mem_sel;
   logic [7:0] in_port_n;
   logic [7:0] out_port_n;
   logic       int_sel_n;
   logic       sel_a;
   logic       sel_b;

   modport src (
      output page_n,
      output mem_sel,
      output in_port_n,
      output out_port_n,
      output int_sel_n,
      output sel_a,
      output sel_b
   );

   modport snk (
      input page_n,
      input mem_sel,
      input in_port_n,
      input out_port_n,
      input int_sel_n,
      input sel_a,
      input sel_b
   );
endinterface : cbd_sel_if

`default_nettype wire

// file: hdl/cbd_decoder.sv
`timescale 1ns/1ps
`default_nettype none

module cbd_decoder
   import cbd_pkg::*;
(
   input  wire logic [15:8] i_addr,
   input  wire logic        i_sinp,
   input  wire logic        i_sout,
   input  wire logic        i_sinta,
   input  wire logic        i_inta_jumper,
   input  wire logic        i_phantom_n,
   input  wire logic        i_pdbin,
   input  wire logic        i_pwr_n,
   cbd_sel_if.src           sel
);

   logic inta_block;
   logic hit_onboard;
   logic hit_zero;
   logic page_en;
   logic port_q;
   logic in_en;
   logic out_en;

   // Selects are pure combinational terms of address and status.
   assign inta_block  = i_inta_jumper & i_sinta;
   assign hit_onboard = (i_addr[15:12] == PAGE_HI_ONBOARD) & i_phantom_n;
   assign hit_zero    = (i_addr[15:12] == PAGE_HI_ZERO) & ~i_phantom_n
                        & (i_addr[11:10] == PAGE_CODE_ROM0);
   assign page_en     = (hit_onboard | hit_zero) & ~i_sinp & ~i_sout & ~inta_block;
   assign sel.mem_sel = page_en;

   assign port_q = (i_addr[15:11] == PORT_HI) & ~inta_block;
   assign in_en  = port_q & i_pdbin & i_sinp;
   assign out_en = port_q & i_sout & ~i_pwr_n;

   genvar gi;
   generate
      for (gi = 0; gi < PAGE_COUNT; gi++) begin : g_page
         assign sel.page_n[gi] = ~(page_en & (i_addr[11:10] == 2'(gi)));
      end
      for (gi = 0; gi < PORT_COUNT; gi++) begin : g_port
         assign sel.in_port_n[gi]  = ~(in_en & (i_addr[10:8] == 3'(gi)));
         assign sel.out_port_n[gi] = ~(out_en & (i_addr[10:8] == 3'(gi)));
      end
   endgenerate

   assign sel.int_sel_n = &sel.in_port_n[INT_PORT_COUNT-1:0];

   // Onboard memory picks the internal bus unless the display page is hit.
   assign sel.sel_a = ~(~sel.in_port_n[PORT_KBD_IDX] | ~sel.int_sel_n
                        | (page_en & sel.page_n[PAGE_DISP]));
   assign sel.sel_b = ~(~sel.in_port_n[PORT_PAR_IDX] | ~sel.int_sel_n
                        | (page_en & sel.page_n[PAGE_DISP]));

endmodule : cbd_decoder

`default_nettype wire

// file: hdl/cbd_input_mux.sv
`timescale 1ns/1ps
`default_nettype none

module cbd_input_mux
   import cbd_pkg::*;
#(
   parameter int WIDTH = 8
) (
   input  wire logic [WIDTH-1:0] i_kbd_data,
   input  wire logic [WIDTH-1:0] i_par_data,
   input  wire logic [WIDTH-1:0] i_int_data,
   input  wire logic [WIDTH-1:0] i_dio_data,
   input  wire logic             i_dbin,
   cbd_sel_if.snk                sel,
   output logic      [WIDTH-1:0] o_data
);

   genvar gb;
   generate
      for (gb = 0; gb < WIDTH; gb++) begin : g_bit
         logic bit_mux;
         always_comb begin
            case (cbd_src_t'({sel.sel_b, sel.sel_a}))
               SRC_INTERNAL: bit_mux = i_int_data[gb];
               SRC_PARALLEL: bit_mux = i_par_data[gb];
               SRC_KEYBOARD: bit_mux = i_kbd_data[gb];
               SRC_BIDIR:    bit_mux = i_dio_data[gb];
               default:      bit_mux = i_dio_data[gb];
            endcase
         end
         // An idle output floats to the pull-up level.
         assign o_data[gb] = i_dbin ? bit_mux : BUS_PULLUP[gb % 8];
      end
   endgenerate

endmodule : cbd_input_mux

`default_nettype wire

// file: hdl/cbd_bus_bridge.sv
// How it works
// - Latch status byte mid-sync, drive status lines.
// - Status drivers off while status disable low.
// - Data-out drivers off on input or disable.
// - Four-way byte mux drives CPU only during DBIN.
// - Both selects high routes bidirectional bus.
// - Keyboard port input selects keyboard bus.
// - Parallel port input selects parallel bus.
// - Internal ports drive both selects low.
// - Onboard memory internal, display page bidirectional.
// - Address drivers off while address disable low.
// - System RAM page writes only with MWRITE.
// - Two read-only ROM page enables.
// - Page decode on top nibble C, four pages.
// - Start-up remap: page 0 to ROM, C ignored.
// - Page decoder off during input or output.
// - One wait state per onboard memory or I/O cycle.
// - Ports F8 to FF from top five bits.
// - Input decode PDBIN and SINP; output SOUT, write.
// - Internal select for input ports F8 to FB.
// - Jumpered interrupt acknowledge blocks all decoders.
// - PDBIN follows DBIN, DIG1 low overrides.
// - Control drivers on only while control disable high.
// - Remap ends after four DBIN pulses.
`timescale 1ns/1ps
`default_nettype none

module cbd_bus_bridge
   import cbd_pkg::*;
(
   input  wire logic        i_clk,
   input  wire logic        i_rst,
   input  wire logic        i_phi2,
   input  wire logic        i_psync,
   input  wire logic [7:0]  i_cpu_d,
   input  wire logic [15:0] i_cpu_addr,
   input  wire logic        i_cpu_dbin,
   input  wire logic        i_cpu_sync,
   input  wire logic        i_cpu_inte,
   input  wire logic        i_cpu_hlda,
   input  wire logic        i_cpu_wr_n,
   input  wire logic        i_cpu_wait,
   input  wire logic        i_sinp,
   input  wire logic        i_sout,
   input  wire logic        i_sinta,
   input  wire logic        i_mwrite,
   input  wire logic        i_pwr_n,
   input  wire logic        i_dig1_n,
   input  wire logic        i_status_bus_disable_n,
   input  wire logic        i_dataout_bus_disable_n,
   input  wire logic        i_address_bus_disable_n,
   input  wire logic        i_control_bus_disable,
   input  wire logic        i_inta_jumper,
   input  wire logic [7:0]  i_kbd_data,
   input  wire logic [7:0]  i_par_data,
   input  wire logic [7:0]  i_int_data,
   input  wire logic [7:0]  i_dio_data,
   output logic      [7:0]  o_status,
   output logic             o_status_oe_n,
   output logic      [7:0]  o_dout,
   output logic             o_dout_oe_n,
   output logic             o_cpu_dataout_inhibit_n,
   output logic      [15:0] o_addr,
   output logic             o_addr_oe_n,
   output logic             o_bus_sync,
   output logic             o_bus_inte,
   output logic             o_bus_hlda,
   output logic             o_bus_wr_n,
   output logic             o_bus_wait,
   output logic             o_pdbin,
   output logic             o_ctrl_oe_n,
   output logic      [7:0]  o_cpu_din,
   output logic             o_cpu_din_oe_n,
   output logic             o_input_select_a,
   output logic             o_input_select_b,
   output logic             o_rom_page0_sel_n,
   output logic             o_rom_page1_sel_n,
   output logic             o_sysram_sel_n,
   output logic             o_sysram_we_n,
   output logic             o_display_ram_page_select_n,
   output logic             o_mem_sel,
   output logic      [7:0]  o_in_port_n,
   output logic      [7:0]  o_out_port_n,
   output logic             o_internal_select_n,
   output logic             o_keyboard_input_strobe_n,
   output logic             o_parallel_input_strobe_n,
   output logic             o_phantom_n,
   output logic             o_prdy_oe_n
);

   cbd_sel_if sel_bus ();

   logic       status_stb;
   logic       status_stb_ff;
   logic       phi2_ff;
   logic       phi2_rise;
   logic       dbin_ff;
   logic       dbin_fall;
   logic       pdbin;
   logic       wait_qual;
   logic [2:0] fetch_cnt_ff;
   logic       phantom_n;
   logic [7:0] mux_data;
   cbd_rdy_t   rdy_state_ff;
   cbd_rdy_t   nxt_rdy_state;

   // Strobe midway through sync: PSYNC while phase 2 is low.
   assign status_stb = i_psync & ~i_phi2;
   assign phi2_rise  = i_phi2 & ~phi2_ff;
   assign dbin_fall  = dbin_ff & ~i_cpu_dbin;
   assign pdbin      = i_cpu_dbin | ~i_dig1_n;
   assign phantom_n  = (fetch_cnt_ff >= PHANTOM_FETCHES);
   assign wait_qual  = sel_bus.mem_sel | i_sinp | i_sout;

   cbd_decoder u_decoder (
      .i_addr        (i_cpu_addr[15:8]),
      .i_sinp        (i_sinp),
      .i_sout        (i_sout),
      .i_sinta       (i_sinta),
      .i_inta_jumper (i_inta_jumper),
      .i_phantom_n   (phantom_n),
      .i_pdbin       (pdbin),
      .i_pwr_n       (i_pwr_n),
      .sel           (sel_bus.src)
   );

   cbd_input_mux #(
      .WIDTH (8)
   ) u_input_mux (
      .i_kbd_data (i_kbd_data),
      .i_par_data (i_par_data),
      .i_int_data (i_int_data),
      .i_dio_data (i_dio_data),
      .i_dbin     (i_cpu_dbin),
      .sel        (sel_bus.snk),
      .o_data     (mux_data)
   );

   // Edge history for phase 2, DBIN and the status strobe.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         phi2_ff       <= 1'b0;
         dbin_ff       <= 1'b0;
         status_stb_ff <= 1'b0;
      end else begin
         phi2_ff       <= i_phi2;
         dbin_ff       <= i_cpu_dbin;
         status_stb_ff <= status_stb;
      end
   end

   // Status latch and its bus drivers.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_status      <= 8'h00;
         o_status_oe_n <= 1'b1;
      end else begin
         if (status_stb & ~status_stb_ff) begin
            o_status <= i_cpu_d;
         end
         o_status_oe_n <= ~i_status_bus_disable_n;
      end
   end

   // Data-out drivers onto the bidirectional bus.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_dout                  <= 8'h00;
         o_dout_oe_n             <= 1'b1;
         o_cpu_dataout_inhibit_n <= 1'b1;
      end else begin
         o_dout                  <= i_cpu_d;
         o_cpu_dataout_inhibit_n <= ~i_cpu_dbin;
         o_dout_oe_n             <= i_cpu_dbin | ~i_dataout_bus_disable_n;
      end
   end

   // Address drivers.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_addr      <= 16'h0000;
         o_addr_oe_n <= 1'b1;
      end else begin
         o_addr      <= i_cpu_addr;
         o_addr_oe_n <= ~i_address_bus_disable_n;
      end
   end

   // Control drivers.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_bus_sync  <= 1'b0;
         o_bus_inte  <= 1'b0;
         o_bus_hlda  <= 1'b0;
         o_bus_wr_n  <= 1'b1;
         o_bus_wait  <= 1'b0;
         o_pdbin     <= 1'b0;
         o_ctrl_oe_n <= 1'b1;
      end else begin
         o_bus_sync  <= i_cpu_sync;
         o_bus_inte  <= i_cpu_inte;
         o_bus_hlda  <= i_cpu_hlda;
         o_bus_wr_n  <= i_cpu_wr_n;
         o_bus_wait  <= i_cpu_wait;
         o_pdbin     <= pdbin;
         o_ctrl_oe_n <= ~i_control_bus_disable;
      end
   end

   // CPU input byte and multiplexer selects.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_cpu_din        <= BUS_PULLUP;
         o_cpu_din_oe_n   <= 1'b1;
         o_input_select_a <= 1'b1;
         o_input_select_b <= 1'b1;
      end else begin
         o_cpu_din        <= mux_data;
         o_cpu_din_oe_n   <= ~i_cpu_dbin;
         o_input_select_a <= sel_bus.sel_a;
         o_input_select_b <= sel_bus.sel_b;
      end
   end

   // Memory page selects.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_rom_page0_sel_n           <= 1'b1;
         o_rom_page1_sel_n           <= 1'b1;
         o_sysram_sel_n              <= 1'b1;
         o_sysram_we_n               <= 1'b1;
         o_display_ram_page_select_n <= 1'b1;
         o_mem_sel                   <= 1'b0;
      end else begin
         o_rom_page0_sel_n           <= sel_bus.page_n[PAGE_ROM0];
         o_rom_page1_sel_n           <= sel_bus.page_n[PAGE_ROM1];
         o_sysram_sel_n              <= sel_bus.page_n[PAGE_SYSRAM];
         o_sysram_we_n               <= sel_bus.page_n[PAGE_SYSRAM] | ~i_mwrite;
         o_display_ram_page_select_n <= sel_bus.page_n[PAGE_DISP];
         o_mem_sel                   <= sel_bus.mem_sel;
      end
   end

   // Port strobes.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_in_port_n               <= 8'hFF;
         o_out_port_n              <= 8'hFF;
         o_internal_select_n       <= 1'b1;
         o_keyboard_input_strobe_n <= 1'b1;
         o_parallel_input_strobe_n <= 1'b1;
      end else begin
         o_in_port_n               <= sel_bus.in_port_n;
         o_out_port_n              <= sel_bus.out_port_n;
         o_internal_select_n       <= sel_bus.int_sel_n;
         o_keyboard_input_strobe_n <= sel_bus.in_port_n[PORT_KBD_IDX];
         o_parallel_input_strobe_n <= sel_bus.in_port_n[PORT_PAR_IDX];
      end
   end

   // Start-up remap counts the end of each of the first four DBIN pulses after clear.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         fetch_cnt_ff <= 3'h0;
         o_phantom_n  <= 1'b0;
      end else begin
         if (dbin_fall && (fetch_cnt_ff < PHANTOM_FETCHES)) begin
            fetch_cnt_ff <= fetch_cnt_ff + 3'h1;
         end
         o_phantom_n <= phantom_n;
      end
   end

   // Wait request from mid-sync until the next phase 2 rise after sync.
   always_comb begin
      nxt_rdy_state = rdy_state_ff;
      case (rdy_state_ff)
         RDY_IDLE: begin
            if (status_stb && wait_qual) begin
               nxt_rdy_state = RDY_WAIT;
            end
         end
         RDY_WAIT: begin
            if (phi2_rise && !i_psync) begin
               nxt_rdy_state = RDY_IDLE;
            end
         end
         default: nxt_rdy_state = RDY_IDLE;
      endcase
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         rdy_state_ff <= RDY_IDLE;
         o_prdy_oe_n  <= 1'b1;
      end else begin
         rdy_state_ff <= nxt_rdy_state;
         o_prdy_oe_n  <= (nxt_rdy_state != RDY_WAIT);
      end
   end

endmodule : cbd_bus_bridge

`default_nettype wire

// file: verif/cbd_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none

module cbd_cpu_model (
   input  wire logic i_clk,
   input  wire logic i_rst,
   input  wire logic i_go,
   input  wire logic i_fetch,
   output logic      o_phi2,
   output logic      o_psync,
   output logic      o_dbin,
   output logic      o_busy
);
   logic [2:0] cnt_ff;
   logic       act_ff;

   // Phase-2 runs free; a machine cycle may start only when the count wraps.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) cnt_ff <= 3'h0;
      else cnt_ff <= cnt_ff + 3'h1;
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) act_ff <= 1'b0;
      else if (cnt_ff == 3'h7) act_ff <= i_go;
   end

   assign o_phi2  = cnt_ff[1];
   assign o_psync = act_ff & ~cnt_ff[2];
   assign o_dbin  = act_ff & i_fetch & cnt_ff[2];
   assign o_busy  = act_ff;
endmodule // cbd_cpu_model

`default_nettype wire

// file: verif/cbd_bus_bridge_sva.sv
`timescale 1ns/1ps
`default_nettype none

module cbd_bus_bridge_sva (
   input wire logic       i_clk,
   input wire logic       i_rst,
   input wire logic       i_phi2,
   input wire logic       i_psync,
   input wire logic [7:0] i_cpu_d,
   input wire logic       i_cpu_dbin,
   input wire logic       i_sinp,
   input wire logic       i_sout,
   input wire logic       i_sinta,
   input wire logic       i_inta_jumper,
   input wire logic       i_dig1_n,
   input wire logic       i_status_bus_disable_n,
   input wire logic       i_dataout_bus_disable_n,
   input wire logic       i_address_bus_disable_n,
   input wire logic       i_control_bus_disable,
   input wire logic [7:0] o_status,
   input wire logic       o_status_oe_n,
   input wire logic       o_dout_oe_n,
   input wire logic       o_addr_oe_n,
   input wire logic       o_ctrl_oe_n,
   input wire logic       o_pdbin,
   input wire logic [7:0] o_cpu_din,
   input wire logic       o_cpu_din_oe_n,
   input wire logic       o_mem_sel,
   input wire logic [7:0] o_in_port_n,
   input wire logic [7:0] o_out_port_n,
   input wire logic       o_prdy_oe_n,
   input wire logic       o_phantom_n
);
   logic live_ff;

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   // Outputs lag their inputs by one edge, so checks start once a full edge has passed.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) live_ff <= 1'b0;
      else live_ff <= 1'b1;
   end

   a_status_load: assert property
      (live_ff && $rose(i_psync & ~i_phi2) |=> o_status == $past(i_cpu_d))
      else $error("status byte not latched");
   a_status_drive: assert property
      (live_ff |-> o_status_oe_n == !$past(i_status_bus_disable_n))
      else $error("status drivers wrong");
   a_dout_drive: assert property
      (live_ff |-> o_dout_oe_n == $past(i_cpu_dbin | ~i_dataout_bus_disable_n))
      else $error("data out drivers wrong");
   a_din_float: assert property
      (live_ff && !$past(i_cpu_dbin) |-> o_cpu_din_oe_n && o_cpu_din == 8'hFF)
      else $error("input mux not floating");
   a_addr_drive: assert property
      (live_ff |-> o_addr_oe_n == !$past(i_address_bus_disable_n))
      else $error("address drivers wrong");
   a_ctrl_drive: assert property
      (live_ff |-> o_ctrl_oe_n == !$past(i_control_bus_disable))
      else $error("control drivers wrong");
   a_pdbin_follow: assert property
      (live_ff |-> o_pdbin == $past(i_cpu_dbin | ~i_dig1_n))
      else $error("pdbin wrong");
   a_page_io_off: assert property
      (live_ff && $past(i_sinp | i_sout) |-> !o_mem_sel)
      else $error("page decode during io");
   a_inta_block: assert property
      (live_ff && $past(i_inta_jumper & i_sinta) |-> !o_mem_sel && &o_in_port_n && &o_out_port_n)
      else $error("decode during interrupt ack");
   a_wait_release: assert property
      ($rose(o_prdy_oe_n) |-> $past(i_phi2) && !$past(i_psync))
      else $error("wait released at wrong edge");
   a_wait_bound: assert property
      (!o_prdy_oe_n |-> ##[1:8] o_prdy_oe_n)
      else $error("wait state too long");
   a_remap_hold: assert property
      (o_phantom_n |=> o_phantom_n)
      else $error("remap came back");
endmodule // cbd_bus_bridge_sva

bind cbd_bus_bridge cbd_bus_bridge_sva u_cbd_bus_bridge_sva (.*);

`default_nettype wire

// file: verif/cbd_bus_bridge_bench.sv
`timescale 1ns/1ps
`default_nettype none

module cbd_bus_bridge_bench;
   logic        i_clk, i_rst, i_phi2, i_psync, i_cpu_dbin, i_cpu_sync, i_cpu_inte, i_cpu_hlda;
   logic        i_cpu_wr_n, i_cpu_wait, i_sinp, i_sout, i_sinta, i_mwrite, i_pwr_n, i_dig1_n;
   logic        i_status_bus_disable_n, i_dataout_bus_disable_n, i_address_bus_disable_n;
   logic        i_control_bus_disable, i_inta_jumper, go, fetch, tb_dbin, m_dbin, m_busy;
   logic [7:0]  i_cpu_d, i_kbd_data, i_par_data, i_int_data, i_dio_data, o_status, o_dout;
   logic [7:0]  o_cpu_din, o_in_port_n, o_out_port_n;
   logic [15:0] i_cpu_addr, o_addr;
   logic        o_status_oe_n, o_dout_oe_n, o_cpu_dataout_inhibit_n, o_addr_oe_n, o_bus_sync;
   logic        o_bus_inte, o_bus_hlda, o_bus_wr_n, o_bus_wait, o_pdbin, o_ctrl_oe_n;
   logic        o_cpu_din_oe_n, o_input_select_a, o_input_select_b, o_rom_page0_sel_n;
   logic        o_rom_page1_sel_n, o_sysram_sel_n, o_sysram_we_n, o_display_ram_page_select_n;
   logic        o_mem_sel, o_internal_select_n, o_keyboard_input_strobe_n;
   logic        o_parallel_input_strobe_n, o_phantom_n, o_prdy_oe_n;
   logic [7:0]  src [4];
   int          err_count, tests_run, lows;

   assign i_cpu_dbin = m_dbin | tb_dbin;

   cbd_bus_bridge u_cbd_bus_bridge (.*);
   cbd_cpu_model u_cbd_cpu_model (.i_clk(i_clk), .i_rst(i_rst), .i_go(go), .i_fetch(fetch),
      .o_phi2(i_phi2), .o_psync(i_psync), .o_dbin(m_dbin), .o_busy(m_busy));

   task automatic step(input int n);
      repeat (n) @(posedge i_clk);
      #2;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      tests_run++;
      if (seen !== exp) begin
         err_count++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic finish_test;
      $display("Checks %0d mismatches %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // Runs one machine cycle of the processor model and counts wait-state cycles.
   task automatic run_cycle(input logic f);
      logic seen;
      seen = 1'b0;
      lows = 0;
      fetch = f;
      go = 1'b1;
      repeat (24) begin
         step(1);
         if (m_busy === 1'b1) begin
            seen = 1'b1;
            go = 1'b0;
         end
         if (o_prdy_oe_n === 1'b0) lows++;
      end
      if (!seen) begin
         err_count++;
         finish_test;
      end
   endtask

   task automatic t_phantom;
      chk("phantom", o_phantom_n, 1'b0);
      i_cpu_addr = 16'h0000;
      step(2);
      chk("rom0", {o_mem_sel, o_rom_page0_sel_n}, 2'h2);
      i_cpu_addr = 16'hC000;
      step(2);
      chk("page_c", o_mem_sel, 1'b0);
      repeat (3) run_cycle(1'b1);
      chk("phantom", o_phantom_n, 1'b0);
      run_cycle(1'b1);
      chk("phantom", o_phantom_n, 1'b1);
      $display("phantom test done");
   endtask

   task automatic t_pages;
      for (int k = 0; k < 4; k++) begin
         i_cpu_addr = {4'hC, k[1:0], 10'h000};
         i_mwrite = 1'b1;
         step(2);
         chk("page", {o_display_ram_page_select_n, o_sysram_sel_n, o_rom_page1_sel_n,
            o_rom_page0_sel_n}, 4'(~(4'h1 << k)));
         chk("mem_sel", o_mem_sel, 1'b1);
         chk("we", o_sysram_we_n, k != 2);
         chk("sel", {o_input_select_b, o_input_select_a}, (k == 3) ? 2'h3 : 2'h0);
      end
      i_mwrite = 1'b0;
      i_cpu_addr = 16'hC800;
      step(2);
      chk("we", o_sysram_we_n, 1'b1);
      i_sinta = 1'b1;
      step(2);
      chk("mem_sel", o_mem_sel, 1'b1);
      i_inta_jumper = 1'b1;
      step(2);
      chk("mem_sel", o_mem_sel, 1'b0);
      {i_inta_jumper, i_sinta} = 2'h0;
      i_sinp = 1'b1;
      step(2);
      chk("mem_sel", o_mem_sel, 1'b0);
      i_sinp = 1'b0;
      i_cpu_addr = 16'hD000;
      step(2);
      chk("mem_sel", o_mem_sel, 1'b0);
      $display("page test done");
   endtask

   task automatic t_ports;
      logic [1:0] e;
      i_sinp = 1'b1;
      i_cpu_addr = 16'hFC00;
      step(2);
      chk("in_port", o_in_port_n, 8'hFF);
      tb_dbin = 1'b1;
      for (int k = 0; k < 8; k++) begin
         i_cpu_addr = {8'hF8 + 8'(k), 8'h00};
         step(2);
         e = (k < 4) ? 2'h0 : (k == 4) ? 2'h2 : (k == 5) ? 2'h1 : 2'h3;
         chk("in_port", o_in_port_n, 8'(~(8'h01 << k)));
         chk("int_sel", o_internal_select_n, k > 3);
         chk("kbd", o_keyboard_input_strobe_n, k != 4);
         chk("par", o_parallel_input_strobe_n, k != 5);
         chk("sel", {o_input_select_b, o_input_select_a}, e);
         chk("din", {o_cpu_din_oe_n, o_cpu_din}, {1'b0, src[e]});
         chk("out_port", o_out_port_n, 8'hFF);
      end
      i_sinp = 1'b0;
      tb_dbin = 1'b0;
      i_sout = 1'b1;
      i_pwr_n = 1'b0;
      i_cpu_addr = 16'hFE00;
      step(2);
      chk("din_idle", {o_cpu_din_oe_n, o_cpu_din}, 9'h1FF);
      chk("out_port", o_out_port_n, 8'hBF);
      i_pwr_n = 1'b1;
      step(2);
      chk("out_port", o_out_port_n, 8'hFF);
      {i_pwr_n, i_inta_jumper, i_sinta} = 3'h3;
      step(2);
      chk("out_port", o_out_port_n, 8'hFF);
      i_inta_jumper = 1'b0;
      step(2);
      chk("out_port", o_out_port_n, 8'hBF);
      {i_sout, i_sinta, i_pwr_n} = 3'h1;
      $display("port test done");
   endtask

   task automatic t_wait;
      i_cpu_addr = 16'hC800;
      i_cpu_d = 8'h5A;
      run_cycle(1'b0);
      chk("wait", 16'(lows), 16'd6);
      chk("status", o_status, 8'h5A);
      i_cpu_addr = 16'h1234;
      run_cycle(1'b0);
      chk("wait", 16'(lows), 16'd0);
      i_sinp = 1'b1;
      i_cpu_d = 8'hA4;
      run_cycle(1'b0);
      chk("wait", 16'(lows), 16'd6);
      chk("status", o_status, 8'hA4);
      i_sinp = 1'b0;
      $display("wait test done");
   endtask

   task automatic t_drivers;
      {i_status_bus_disable_n, i_dataout_bus_disable_n, i_address_bus_disable_n} = 3'h0;
      {i_control_bus_disable, i_dig1_n} = 2'h0;
      {i_cpu_sync, i_cpu_inte, i_cpu_hlda, i_cpu_wr_n, i_cpu_wait} = 5'h15;
      i_cpu_addr = 16'hA55A;
      i_cpu_d = 8'h3C;
      step(2);
      chk("oe_off", {o_status_oe_n, o_dout_oe_n, o_addr_oe_n, o_ctrl_oe_n}, 4'hF);
      chk("pdbin", o_pdbin, 1'b1);
      {i_status_bus_disable_n, i_dataout_bus_disable_n, i_address_bus_disable_n} = 3'h7;
      {i_control_bus_disable, i_dig1_n} = 2'h3;
      step(2);
      chk("oe_on", {o_status_oe_n, o_dout_oe_n, o_addr_oe_n, o_ctrl_oe_n}, 4'h0);
      chk("pdbin", o_pdbin, 1'b0);
      chk("ctrl", {o_bus_sync, o_bus_inte, o_bus_hlda, o_bus_wr_n, o_bus_wait}, 5'h15);
      chk("addr", o_addr, 16'hA55A);
      chk("dout", o_dout, 8'h3C);
      tb_dbin = 1'b1;
      step(2);
      chk("dout_in", {o_dout_oe_n, o_cpu_dataout_inhibit_n}, 2'h2);
      tb_dbin = 1'b0;
      $display("driver test done");
   endtask

   initial begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   initial begin
      i_rst = 1'b1;
      {go, fetch, tb_dbin, i_cpu_sync, i_cpu_inte, i_cpu_hlda, i_cpu_wait} = 7'h00;
      {i_sinp, i_sout, i_sinta, i_mwrite, i_inta_jumper} = 5'h00;
      {i_cpu_wr_n, i_pwr_n, i_dig1_n, i_control_bus_disable} = 4'hF;
      {i_status_bus_disable_n, i_dataout_bus_disable_n, i_address_bus_disable_n} = 3'h7;
      i_cpu_d = 8'h00;
      i_cpu_addr = 16'hC000;
      src = '{8'hC3, 8'hB2, 8'hA1, 8'hD4};
      {i_int_data, i_par_data, i_kbd_data, i_dio_data} = {src[0], src[1], src[2], src[3]};
      err_count = 0;
      tests_run = 0;
      step(6);
      i_rst = 1'b0;
      step(2);
      chk("prdy", o_prdy_oe_n, 1'b1);
      t_phantom;
      t_pages;
      t_ports;
      t_wait;
      t_drivers;
      finish_test;
   end
endmodule // cbd_bus_bridge_bench

`default_nettype wire
